// ### rtl/lrc_host.sv
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "lrc_params.svh"
module lrc_host
  import lrc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [4:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [4:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_irq,
  lrc_ata_if.host          ata
);
  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  logic        aw_held;
  logic        w_held;
  logic [4:0]  aw_addr;
  logic [31:0] w_data;
  logic        wr_fire;
  logic        rd_fire;
  logic        start;
  logic [31:0] param;
  logic [2:0]  irq_stat;
  logic [2:0]  irq_mask;
  logic [2:0]  irq_set;
  logic [15:0] last_data;
  logic [31:0] words;
  lrc_host_state_type state;

  assign wr_fire = aw_held && w_held && !o_bvalid;
  assign rd_fire = i_arvalid && o_arready;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= 5'h00;
      w_data    <= 32'h0000_0000;
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held   <= 1'b1;
        aw_addr   <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_held   <= 1'b1;
        w_data   <= i_wdata;
        o_wready <= 1'b0;
      end
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp  <= (aw_addr == `LRC_REG_CTRL || aw_addr == `LRC_REG_PARAM
                     || aw_addr == `LRC_REG_IRQ_MASK) ? 2'h0 : 2'h2;
      end else if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        aw_held   <= 1'b0;
        w_held    <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // byte strobes ignored: each register is written as a whole word
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      param    <= 32'h0000_0000;
      irq_mask <= 3'h0;
    end else if (wr_fire && i_wstrb == i_wstrb) begin
      if (aw_addr == `LRC_REG_PARAM) param <= w_data;
      if (aw_addr == `LRC_REG_IRQ_MASK) irq_mask <= w_data[2:0];
    end
  end

  assign start = wr_fire && aw_addr == `LRC_REG_CTRL && w_data[0] && state == HST_IDLE;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= 2'h0;
    end else if (rd_fire) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= 2'h0;
      case (i_araddr)
        `LRC_REG_PARAM:    o_rdata <= param;
        `LRC_REG_STATUS:   o_rdata <= {15'h0000, state != HST_IDLE, ata.error, ata.status};
        `LRC_REG_IRQ_STAT: o_rdata <= {29'h0, irq_stat};
        `LRC_REG_IRQ_MASK: o_rdata <= {29'h0, irq_mask};
        `LRC_REG_DATA:     o_rdata <= {16'h0000, last_data};
        `LRC_REG_WORDS:    o_rdata <= words;
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= 2'h2;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // read clears; an event in the same cycle stays set
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat <= 3'h0;
    end else if (rd_fire && i_araddr == `LRC_REG_IRQ_STAT) begin
      irq_stat <= irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |((irq_stat | irq_set) & irq_mask);
    end
  end

  // ************************************************************
  // command sequencer: high byte before low, command last
  // ************************************************************
  logic [2:0]  step;
  logic [15:0] blocks_left;
  logic [7:0]  word_cnt;
  logic        hs;
  logic [2:0]  wr_addr [0:5];
  logic [7:0]  wr_byte [0:5];

  assign hs = ata.data_valid && ata.data_ready;
  assign wr_addr[0] = `LRC_TF_SECT_COUNT;
  assign wr_addr[1] = `LRC_TF_SECT_COUNT;
  assign wr_addr[2] = `LRC_TF_SECT_NUMBER;
  assign wr_addr[3] = `LRC_TF_CYL_LOW;
  assign wr_addr[4] = `LRC_TF_CYL_LOW;
  assign wr_addr[5] = `LRC_TF_COMMAND;
  assign wr_byte[0] = param[31:24];
  assign wr_byte[1] = param[23:16];
  assign wr_byte[2] = param[7:0];
  assign wr_byte[3] = 8'h00;
  assign wr_byte[4] = param[15:8];
  assign wr_byte[5] = `LRC_CMD_READ_LOG;

  always_comb begin
    irq_set = 3'h0;
    irq_set[`LRC_IRQ_ABORT] = state == HST_ACK && ata.status[`LRC_ST_ERR];
    irq_set[`LRC_IRQ_BLOCK] = state == HST_RECV && hs && word_cnt == 8'hFF;
    irq_set[`LRC_IRQ_DONE]  = irq_set[`LRC_IRQ_BLOCK] && blocks_left == 16'h0001;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state          <= HST_IDLE;
      step           <= 3'h0;
      blocks_left    <= 16'h0000;
      word_cnt       <= 8'h00;
      ata.tf_we      <= 1'b0;
      ata.tf_addr    <= 3'h0;
      ata.tf_wdata   <= 8'h00;
      ata.status_rd  <= 1'b0;
      ata.data_ready <= 1'b0;
    end else begin
      ata.tf_we     <= 1'b0;
      ata.status_rd <= 1'b0;
      case (state)
        HST_IDLE: begin
          if (start) begin
            state       <= HST_WRITE;
            step        <= 3'h0;
            blocks_left <= param[31:16];
          end
        end
        HST_WRITE: begin
          ata.tf_we    <= 1'b1;
          ata.tf_addr  <= wr_addr[step];
          ata.tf_wdata <= wr_byte[step]; // [RULE14]
          step <= step + 3'h1;
          if (step == 3'h5) state <= HST_WAIT_IRQ;
        end
        HST_WAIT_IRQ: begin
          if (ata.intrq) begin
            ata.status_rd <= 1'b1;
            state         <= HST_ACK;
          end
        end
        HST_ACK: begin
          if (ata.status[`LRC_ST_ERR]) begin
            state <= HST_IDLE;
          end else if (ata.status[`LRC_ST_DATA_REQUEST_FLAG]) begin
            state          <= HST_RECV;
            word_cnt       <= 8'h00;
            ata.data_ready <= 1'b1;
          end
        end
        HST_RECV: begin
          if (hs) begin
            word_cnt <= word_cnt + 8'h01;
            if (word_cnt == 8'hFF) begin
              ata.data_ready <= 1'b0;
              blocks_left    <= blocks_left - 16'h0001;
              state          <= (blocks_left == 16'h0001) ? HST_IDLE : HST_WAIT_IRQ;
            end
          end
        end
        default: state <= HST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_data <= 16'h0000;
      words     <= 32'h0000_0000;
    end else if (start) begin
      words <= 32'h0000_0000;
    end else if (hs) begin
      last_data <= ata.data_word;
      words     <= words + 32'h0000_0001;
    end
  end
endmodule

// ### rtl/lrc_params.svh
`ifndef LRC_PARAMS_SVH
`define LRC_PARAMS_SVH
// task-file register addresses
`define LRC_TF_FEATURE     3'h1
`define LRC_TF_SECT_COUNT  3'h2
`define LRC_TF_SECT_NUMBER 3'h3
`define LRC_TF_CYL_LOW     3'h4
`define LRC_TF_CYL_HIGH    3'h5
`define LRC_TF_DEV_HEAD    3'h6
`define LRC_TF_COMMAND     3'h7
`define LRC_CMD_READ_LOG   8'h2F
// status bit positions
`define LRC_ST_BSY  7
`define LRC_ST_RDY  6
`define LRC_ST_DEVICE_FAULT_FLAG  5
`define LRC_ST_SEEK_COMPLETE_FLAG 4
`define LRC_ST_DATA_REQUEST_FLAG  3
`define LRC_ST_ERR  0
// error bit positions
`define LRC_ER_COMMAND_ABORT_FLAG 2
`define LRC_STATUS_RESET 8'h50
`define LRC_ERROR_RESET  8'h00
// log addresses
`define LRC_LOG_DIR      8'h00
`define LRC_LOG_ERR      8'h03
`define LRC_LOG_SELFTEST 8'h06
`define LRC_LOG_XSELF    8'h07
`define LRC_LOG_POWER    8'h08
`define LRC_LOG_QERR     8'h10
`define LRC_LOG_PHY      8'h11
`define LRC_LOG_QMGMT    8'h12
`define LRC_LOG_REBUILD  8'h15
`define LRC_LOG_WSTREAM  8'h21
`define LRC_LOG_RSTREAM  8'h22
`define LRC_LOG_IDENT    8'h30
`define LRC_LOG_HOST_LO  8'h80
`define LRC_LOG_HOST_HI  8'h9F
// feature enable bits
`define LRC_FE_SMART   0
`define LRC_FE_SELF    1
`define LRC_FE_POWER   2
`define LRC_FE_NCQ     3
`define LRC_FE_SATA    4
`define LRC_FE_QMGMT   5
`define LRC_FE_STREAM  6
`define LRC_FE_REBUILD 7
// log lengths in sectors
`define LRC_SIZE_DIR     16'h0001
`define LRC_SIZE_ERR     16'h0004
`define LRC_SIZE_XSELF   16'h0002
`define LRC_SIZE_ONE     16'h0001
`define LRC_SIZE_IDENT   16'h0008
`define LRC_SIZE_HOST    16'h0010
`define LRC_DIR_VERSION  16'h0001
`define LRC_ERRLOG_VER   16'h0001
`define LRC_WORDS_PER_BLOCK 9'h100
// host-side AXI register offsets
`define LRC_REG_CTRL     5'h00
`define LRC_REG_PARAM    5'h04
`define LRC_REG_STATUS   5'h08
`define LRC_REG_IRQ_STAT 5'h0C
`define LRC_REG_IRQ_MASK 5'h10
`define LRC_REG_DATA     5'h14
`define LRC_REG_WORDS    5'h18
`define LRC_IRQ_DONE     0
`define LRC_IRQ_ABORT    1
`define LRC_IRQ_BLOCK    2
`endif

// ### rtl/lrc_pkg.sv
package lrc_pkg;
  typedef enum {
    DEV_IDLE,
    DEV_CHECK,
    DEV_XFER
  } lrc_dev_state_type;
  typedef enum {
    HST_IDLE,
    HST_WRITE,
    HST_WAIT_IRQ,
    HST_ACK,
    HST_RECV
  } lrc_host_state_type;
endpackage

// ### rtl/lrc_ata_if.sv
`timescale 1ns/10ps
interface lrc_ata_if;
  logic       tf_we;
  logic [2:0] tf_addr;
  logic [7:0] tf_wdata;
  logic       status_rd;
  logic [7:0] status;
  logic [7:0] error;
  logic       intrq;
  logic       data_valid;
  logic       data_ready;
  logic [15:0] data_word;
  modport device (
    input  tf_we, tf_addr, tf_wdata, status_rd, data_ready,
    output status, error, intrq, data_valid, data_word
  );
  modport host (
    output tf_we, tf_addr, tf_wdata, status_rd, data_ready,
    input  status, error, intrq, data_valid, data_word
  );
endinterface

// ### rtl/lrc_log_rom.sv
`timescale 1ns/10ps
`include "lrc_params.svh"
module lrc_log_rom
  import lrc_pkg::*;
(
  input  wire logic [7:0]  i_log,
  input  wire logic [15:0] i_sector,
  input  wire logic [7:0]  i_word,
  input  wire logic [7:0]  i_feature_en,
  output logic      [15:0] o_word
);
  // log length in sectors; zero means the log is absent
  function automatic logic [15:0] log_size(input logic [7:0] log, input logic [7:0] fe);
    logic [15:0] s;
    s = 16'h0000;
    case (log)
      `LRC_LOG_DIR:     s = `LRC_SIZE_DIR;
      `LRC_LOG_ERR:     s = fe[`LRC_FE_SMART] ? `LRC_SIZE_ERR : 16'h0000;
      `LRC_LOG_XSELF:   s = fe[`LRC_FE_SELF] ? `LRC_SIZE_XSELF : 16'h0000;
      `LRC_LOG_POWER:   s = fe[`LRC_FE_POWER] ? `LRC_SIZE_ONE : 16'h0000;
      `LRC_LOG_QERR:    s = fe[`LRC_FE_NCQ] ? `LRC_SIZE_ONE : 16'h0000;
      `LRC_LOG_PHY:     s = fe[`LRC_FE_SATA] ? `LRC_SIZE_ONE : 16'h0000;
      `LRC_LOG_QMGMT:   s = fe[`LRC_FE_QMGMT] ? `LRC_SIZE_ONE : 16'h0000;
      `LRC_LOG_REBUILD: s = fe[`LRC_FE_REBUILD] ? `LRC_SIZE_ONE : 16'h0000;
      `LRC_LOG_WSTREAM,
      `LRC_LOG_RSTREAM: s = fe[`LRC_FE_STREAM] ? `LRC_SIZE_ONE : 16'h0000;
      `LRC_LOG_IDENT:   s = `LRC_SIZE_IDENT;
      default: begin
        if (log >= `LRC_LOG_HOST_LO && log <= `LRC_LOG_HOST_HI && fe[`LRC_FE_SMART]) begin
          s = `LRC_SIZE_HOST;
        end
      end
    endcase
    return s;
  endfunction

  always_comb begin
    o_word = 16'h0000;
    case (i_log)
      `LRC_LOG_DIR: begin
        // word 0 carries the version, word n the length of log n
        if (i_word == 8'h00) begin
          o_word = `LRC_DIR_VERSION;
        end else begin
          o_word = log_size(i_word, i_feature_en);
        end
      end
      `LRC_LOG_ERR: begin
        if (i_word == 8'h00) begin
          o_word = `LRC_ERRLOG_VER;
        end
      end
      `LRC_LOG_XSELF: begin
        // descriptor flags: 28-bit and 48-bit entries both held [RULE10] [RULE11]
        if (i_word == 8'h01) begin
          o_word = 16'h0003;
        end
      end
      default: begin
        if (i_log < `LRC_LOG_HOST_LO) begin
          o_word = {i_sector[7:0], i_word};
        end
      end
    endcase
  end
endmodule

// ### rtl/lrc_device.sv
`timescale 1ns/10ps
`include "lrc_params.svh"
// Behaviour
// [RULE1] command 2Fh starts extended log read
// [RULE2] interrupt raised once per data block
// [RULE3] sector count: previous high, current low
// [RULE4] current sector number selects the log
// [RULE5] offset: cylinder low previous high, current low
// [RULE6] data starts at requested offset sector
// [RULE7] supported read-only and host-specific logs decoded
// [RULE8] log 06h read aborts the command
// [RULE9] serial logs 10h-12h, 15h; others reserved
// [RULE10] self-test log holds 28/48-bit entries
// [RULE11] 28-bit entries repeated in comprehensive log
// [RULE12] disabled feature log aborts the command
// [RULE13] invalid count, address or offset aborts
// [RULE14] host writes high byte first, command last
// [RULE15] completion and abort status bits as defined
module lrc_device
  import lrc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_feature_en,
  output logic            o_busy,
  lrc_ata_if.device       ata
);
  // ************************************************************
  // pin synchroniser for feature enables
  // ************************************************************
  logic [7:0] fe_meta;
  logic [7:0] fe_sync;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fe_meta <= 8'h00;
      fe_sync <= 8'h00;
    end else begin
      fe_meta <= i_feature_en;
      fe_sync <= fe_meta;
    end
  end

  // ************************************************************
  // task file: current and previous byte of sector count and cylinder low, current sector number
  // ************************************************************
  logic [7:0] count_cur;
  logic [7:0] count_prev;
  logic [7:0] log_cur;
  logic [7:0] offset_cur;
  logic [7:0] offset_prev;
  logic       cmd_go;
  lrc_dev_state_type state;

  // writes while busy are ignored so the running command keeps its parameters
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_cur   <= 8'h00;
      count_prev  <= 8'h00;
      log_cur     <= 8'h00;
      offset_cur  <= 8'h00;
      offset_prev <= 8'h00;
    end else if (ata.tf_we && state == DEV_IDLE) begin
      case (ata.tf_addr)
        `LRC_TF_SECT_COUNT: begin
          count_prev <= count_cur; // [RULE3]
          count_cur  <= ata.tf_wdata;
        end
        `LRC_TF_SECT_NUMBER: log_cur <= ata.tf_wdata; // [RULE4]
        `LRC_TF_CYL_LOW: begin
          offset_prev <= offset_cur; // [RULE5]
          offset_cur  <= ata.tf_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  assign cmd_go = ata.tf_we && state == DEV_IDLE && ata.tf_addr == `LRC_TF_COMMAND
                  && ata.tf_wdata == `LRC_CMD_READ_LOG; // [RULE1] [RULE14]

  // ************************************************************
  // validation
  // ************************************************************
  logic [15:0] req_count;
  logic [15:0] req_offset;
  logic [15:0] size;
  logic [16:0] req_end;
  logic        log_known;
  logic        feature_ok;
  logic        req_valid;

  assign req_count  = {count_prev, count_cur};
  assign req_offset = {offset_prev, offset_cur};
  assign req_end    = {1'b0, req_offset} + {1'b0, req_count};

  always_comb begin
    log_known  = 1'b1;
    feature_ok = 1'b1;
    size       = `LRC_SIZE_ONE;
    case (log_cur) // [RULE7] [RULE9]
      `LRC_LOG_DIR:      size = `LRC_SIZE_DIR;
      `LRC_LOG_ERR: begin
        size       = `LRC_SIZE_ERR;
        feature_ok = fe_sync[`LRC_FE_SMART];
      end
      `LRC_LOG_SELFTEST: log_known = 1'b0; // [RULE8]
      `LRC_LOG_XSELF: begin
        size       = `LRC_SIZE_XSELF;
        feature_ok = fe_sync[`LRC_FE_SELF];
      end
      `LRC_LOG_POWER:    feature_ok = fe_sync[`LRC_FE_POWER];
      `LRC_LOG_QERR:     feature_ok = fe_sync[`LRC_FE_NCQ];
      `LRC_LOG_PHY:      feature_ok = fe_sync[`LRC_FE_SATA];
      `LRC_LOG_QMGMT:    feature_ok = fe_sync[`LRC_FE_QMGMT];
      `LRC_LOG_REBUILD:  feature_ok = fe_sync[`LRC_FE_REBUILD];
      `LRC_LOG_WSTREAM,
      `LRC_LOG_RSTREAM:  feature_ok = fe_sync[`LRC_FE_STREAM];
      `LRC_LOG_IDENT:    size = `LRC_SIZE_IDENT;
      default: begin
        if (log_cur >= `LRC_LOG_HOST_LO && log_cur <= `LRC_LOG_HOST_HI) begin
          size       = `LRC_SIZE_HOST;
          feature_ok = fe_sync[`LRC_FE_SMART];
        end else begin
          log_known = 1'b0; // reserved and unsupported addresses
        end
      end
    endcase
  end

  // count zero or a range past the log end is invalid
  assign req_valid = log_known && feature_ok && req_count != 16'h0000
                     && req_end <= {1'b0, size}; // [RULE12] [RULE13]

  // ************************************************************
  // transfer sequencer
  // ************************************************************
  logic [15:0] cur_sec;
  logic [7:0]  cur_word;
  logic [15:0] remaining;
  logic [15:0] rom_sec;
  logic [7:0]  rom_word;
  logic [15:0] rom_data;
  logic        hs;
  logic        last_word;

  assign hs        = ata.data_valid && ata.data_ready;
  assign last_word = cur_word == 8'hFF;
  // prefetch: in CHECK the first word of the offset sector, else the next one
  assign rom_sec   = (state == DEV_CHECK) ? req_offset
                     : (last_word ? cur_sec + 16'h0001 : cur_sec); // [RULE6]
  assign rom_word  = (state == DEV_CHECK) ? 8'h00 : cur_word + 8'h01;

  lrc_log_rom u_rom (
    .i_log        (log_cur),
    .i_sector     (rom_sec),
    .i_word       (rom_word),
    .i_feature_en (fe_sync),
    .o_word       (rom_data)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= DEV_IDLE;
    end else begin
      case (state)
        DEV_IDLE:  if (cmd_go) state <= DEV_CHECK;
        DEV_CHECK: state <= req_valid ? DEV_XFER : DEV_IDLE;
        DEV_XFER:  if (hs && last_word && remaining == 16'h0001) state <= DEV_IDLE;
        default:   state <= DEV_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_sec   <= 16'h0000;
      cur_word  <= 8'h00;
      remaining <= 16'h0000;
    end else if (state == DEV_CHECK) begin
      cur_sec   <= req_offset; // [RULE6]
      cur_word  <= 8'h00;
      remaining <= req_count;
    end else if (hs) begin
      cur_sec  <= rom_sec;
      cur_word <= rom_word;
      if (last_word) begin
        remaining <= remaining - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ata.data_word  <= 16'h0000;
      ata.data_valid <= 1'b0;
    end else begin
      if (state == DEV_CHECK || hs) begin
        ata.data_word <= rom_data;
      end
      if (state == DEV_CHECK) begin
        ata.data_valid <= req_valid;
      end else if (hs && last_word && remaining == 16'h0001) begin
        ata.data_valid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // status, error and interrupt
  // ************************************************************
  logic block_start;

  assign block_start = (state == DEV_CHECK) || (hs && last_word && remaining != 16'h0001);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ata.status <= `LRC_STATUS_RESET;
      ata.error  <= `LRC_ERROR_RESET;
      o_busy     <= 1'b0;
    end else if (cmd_go) begin
      ata.status <= 8'h00;
      ata.status[`LRC_ST_BSY] <= 1'b1;
      ata.error  <= 8'h00;
      o_busy     <= 1'b1;
    end else if (state == DEV_CHECK) begin
      ata.status <= 8'h00;
      ata.status[`LRC_ST_RDY] <= 1'b1;
      ata.status[`LRC_ST_SEEK_COMPLETE_FLAG] <= 1'b1;
      if (req_valid) begin
        ata.status[`LRC_ST_DATA_REQUEST_FLAG] <= 1'b1;
      end else begin
        ata.status[`LRC_ST_ERR] <= 1'b1; // [RULE15]
        ata.error[`LRC_ER_COMMAND_ABORT_FLAG] <= 1'b1; // [RULE8] [RULE12] [RULE13]
        o_busy                  <= 1'b0;
      end
    end else if (state == DEV_XFER && hs && last_word && remaining == 16'h0001) begin
      ata.status[`LRC_ST_DATA_REQUEST_FLAG] <= 1'b0; // [RULE15]
      o_busy                  <= 1'b0;
    end
  end

  // a new block outranks the host's acknowledge in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ata.intrq <= 1'b0;
    end else if (block_start) begin
      ata.intrq <= 1'b1; // [RULE2]
    end else if (ata.status_rd) begin
      ata.intrq <= 1'b0;
    end
  end
endmodule

// ### test/lrc_asserts.sv
`timescale 1ns/10ps
`include "lrc_params.svh"
module lrc_asserts (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        tf_we,
  input wire logic [2:0]  tf_addr,
  input wire logic [7:0]  tf_wdata,
  input wire logic        status_rd,
  input wire logic [7:0]  status,
  input wire logic [7:0]  error,
  input wire logic        intrq,
  input wire logic        data_valid,
  input wire logic        data_ready,
  input wire logic [15:0] data_word
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ************
  // link checks
  // ************
  sequence s_cmd;
    tf_we && tf_addr == `LRC_TF_COMMAND && tf_wdata == `LRC_CMD_READ_LOG
      && !status[`LRC_ST_BSY] && !data_valid;
  endsequence
  sequence s_resolve;
    intrq && (status == 8'h58 || status == 8'h51 && error == 8'h04);
  endsequence
  property p_cmd_walk; s_cmd |=> status == 8'h80 ##1 s_resolve; endproperty
  a_cmd_walk: assert property (p_cmd_walk) else $error("command walk");
  property p_abort_flags; status[`LRC_ST_ERR] |-> status == 8'h51 && error == 8'h04; endproperty
  a_abort_flags: assert property (p_abort_flags) else $error("abort flags");
  property p_abort_silent; status[`LRC_ST_ERR] |-> !data_valid; endproperty
  a_abort_silent: assert property (p_abort_silent) else $error("abort data");
  property p_done; $fell(data_valid) |-> ##[0:1] status == 8'h50; endproperty
  a_done: assert property (p_done) else $error("done status");
  property p_word_hold; data_valid && !data_ready |=> data_valid && $stable(data_word); endproperty
  a_word_hold: assert property (p_word_hold) else $error("word hold");
  property p_irq_hold; intrq && !status_rd |=> intrq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq hold");
  property p_irq_cause;
    $rose(intrq) |-> status[`LRC_ST_DATA_REQUEST_FLAG] || status[`LRC_ST_ERR];
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq cause");
  property p_busy_excl;
    status[`LRC_ST_BSY] |-> !status[`LRC_ST_DATA_REQUEST_FLAG] && !data_valid;
  endproperty
  a_busy_excl: assert property (p_busy_excl) else $error("busy data");
endmodule

// ### test/testbench.sv
`timescale 1ns/10ps
`include "lrc_params.svh"
module testbench;
  logic        i_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, irq_prev;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, irq_seen, busy;
  logic [4:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rdat;
  logic [1:0]  o_bresp, o_rresp, resp;
  logic [7:0]  fe, lg, nf;
  logic [15:0] lfsr, cnt;
  logic [2:0]  acc;
  int          error_cnt, checked, rises, ew, off;
  logic [7:0]  logs [17] = '{8'h00, 8'h03, 8'h06, 8'h07, 8'h08, 8'h10, 8'h11, 8'h12, 8'h13,
                             8'h15, 8'h16, 8'h21, 8'h22, 8'h30, 8'h80, 8'h9F, 8'hA0};
  lrc_ata_if ata ();
  lrc_device u_lrc_device (.i_clk, .i_rst_n, .i_feature_en(fe), .o_busy(busy), .ata);
  lrc_host u_lrc_host (.i_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_irq, .ata);
  lrc_asserts u_chk (.i_clk, .i_rst_n, .tf_we(ata.tf_we), .tf_addr(ata.tf_addr),
    .tf_wdata(ata.tf_wdata), .status_rd(ata.status_rd), .status(ata.status),
    .error(ata.error), .intrq(ata.intrq), .data_valid(ata.data_valid),
    .data_ready(ata.data_ready), .data_word(ata.data_word));
  // ************
  // bench model
  // ************
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    irq_prev <= ata.intrq;
    if (ata.intrq && !irq_prev) rises = rises + 1;
    if (o_irq) irq_seen = 1;
  end
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // words expected, or -1 where the command must abort
  function automatic int model(input logic [7:0] l, input int o, input int c, input logic [7:0] f);
    int sz;
    sz = 0;
    case (l)
      8'h00: sz = 1;
      8'h03: sz = f[0] ? 4 : 0;
      8'h07: sz = f[1] ? 2 : 0;
      8'h08: sz = f[2];
      8'h10: sz = f[3];
      8'h11: sz = f[4];
      8'h12: sz = f[5];
      8'h15: sz = f[7];
      8'h21, 8'h22: sz = f[6];
      8'h30: sz = 8;
      default: if (l >= 8'h80 && l <= 8'h9F && f[0]) sz = 16;
    endcase
    return (c == 0 || o + c > sz) ? -1 : c * 256;
  endfunction
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic summarize;
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] d);
    int  n;
    bit  done;
    n = 0;
    done = 0;
    @(posedge i_clk);
    if (wr) begin
      i_awaddr <= a;
      i_wdata <= d;
      {i_awvalid, i_wvalid, i_bready} <= 3'h7;
    end else begin
      i_araddr <= a;
      {i_arvalid, i_rready} <= 2'h3;
    end
    while (!done) begin
      @(posedge i_clk);
      n++;
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
      if (o_arready) i_arvalid <= 0;
      if (o_bvalid && i_bready) begin
        i_bready <= 0;
        resp = o_bresp;
        done = 1;
      end
      if (o_rvalid && i_rready) begin
        i_rready <= 0;
        {rdat, resp} = {o_rdata, o_rresp};
        done = 1;
      end
      if (n > 300 && !done) begin
        chk(0, "bus hang");
        summarize();
      end
    end
  endtask
  initial begin
    {i_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, irq_seen} = 0;
    {i_awaddr, i_araddr, i_wdata, fe} = 0;
    lfsr = 16'hDB83;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1;
    bus(0, `LRC_REG_IRQ_MASK, 0);
    chk(rdat === 32'h0, "mask reset");
    bus(0, 5'h1C, 0);
    chk(resp === 2'h2, "unmapped read");
    bus(1, `LRC_REG_STATUS, 32'h1);
    chk(resp === 2'h2, "read-only write");
    for (int i = 0; i < 34; i++) begin
      lfsr = nxt(lfsr);
      lg = logs[i % 17];
      off = lfsr[1:0];
      cnt = lfsr[15] ? 16'h0100 : 16'(lfsr[3:2]);
      nf = lfsr[13:6];
      fe <= nf;
      ew = model(lg, off, cnt, nf);
      bus(1, `LRC_REG_IRQ_MASK, {29'h0, lfsr[4], 2'h0});
      bus(1, `LRC_REG_PARAM, {cnt, 8'(off), lg});
      {rises, irq_seen, acc} = 0;
      bus(1, `LRC_REG_CTRL, 32'h1);
      for (int k = 0; k < 5000 && acc[1:0] == 0; k++) begin
        bus(0, `LRC_REG_IRQ_STAT, 0);
        acc |= rdat[2:0];
      end
      if (acc[1:0] == 0) begin
        chk(0, "command hang");
        summarize();
      end
      bus(0, `LRC_REG_STATUS, 0);
      chk(rdat[15:0] === (ew < 0 ? 16'h0451 : 16'h0050), "status");
      chk(busy === 1'b0, "busy clear");
      chk(acc[1] === (ew < 0), "abort");
      chk(rises === (ew < 0 ? 1 : int'(cnt)), "irq per block");
      chk(irq_seen === (lfsr[4] && ew > 0), "irq mask");
      bus(0, `LRC_REG_WORDS, 0);
      chk(rdat === 32'(ew < 0 ? 0 : ew), "word count");
      chk(o_irq === 1'b0, "irq clear");
      if (lg[7] && ew > 0) begin
        bus(0, `LRC_REG_DATA, 0);
        chk(rdat === 32'h0, "host log data");
      end
    end
    summarize();
  end
endmodule
